//--- design/tcmc_pkg.sv
package tcmc_pkg;
   // Register offsets on the plain register port (pointer values)
   localparam logic [1:0] ADDR_TEMP = 2'h0;
   localparam logic [1:0] ADDR_CONF = 2'h1;
   localparam logic [1:0] ADDR_TLOW = 2'h2;
   localparam logic [1:0] ADDR_THIGH = 2'h3;
   // Extra registers, reached with the high address bit set
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
   localparam logic [2:0] ADDR_SAMPLE = 3'h6;
   localparam logic [2:0] ADDR_STATE = 3'h7;
   // Configuration field positions
   localparam int CONF_SINGLE_SHOT_POS = 15;
   localparam int CONF_RATE_HI_POS = 14;
   localparam int CONF_RATE_LO_POS = 13;
   localparam int CONF_THERMOSTAT_POS = 9;
   localparam int CONF_POWER_DOWN_POS = 8;
   // Reset values
   localparam logic [15:0] CONF_RESET = 16'h00ff;
   localparam logic [15:0] TLOW_RESET = 16'h4b00;
   localparam logic [15:0] THIGH_RESET = 16'h5000;
   localparam logic [15:0] TEMP_RESET = 16'h0000;
   localparam logic [7:0] CONF_RESERVED = 8'hff;
   // Interrupt status bit positions
   localparam int IRQ_DONE_POS = 0;
   localparam int IRQ_SHUTDOWN_POS = 1;
   localparam int IRQ_SINGLE_POS = 2;
   localparam int IRQ_W = 3;
   // Timing: conversion time and rate periods
   localparam int CLK_MHZ = 250;
   localparam int CONV_TIME_US = 27000;
   localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
   localparam int RATE_18HZ = 18;
   localparam int RATE_9HZ = 9;
   localparam int RATE_4HZ = 4;
   localparam int CLK_HZ = CLK_MHZ * 1000000;
   // Idle delay = period minus conversion time, rounded down
   localparam int DELAY_18_CYCLES = CLK_HZ / RATE_18HZ - CONV_CYCLES;
   localparam int DELAY_9_CYCLES = CLK_HZ / RATE_9HZ - CONV_CYCLES;
   localparam int DELAY_4_CYCLES = CLK_HZ / RATE_4HZ - CONV_CYCLES;

   typedef enum logic [1:0] {
      TCMC_CONVERT = 2'b00,
      TCMC_DELAY = 2'b01,
      TCMC_SHUTDOWN = 2'b11
   } tcmc_state_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
      logic [1:0] byte_en;
   } tcmc_req_t;
endpackage

//--- design/tcmc_top.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - Continuous conversions each overwrite the temperature result register.
// - Rate field 00/01/10/11 selects 37, 18, 9, 4 Hz.
// - A conversion takes 27 ms from start to result.
// - Slower rates: convert, power down, wait selected delay, convert again.
// - At 37 Hz the next conversion starts right after the last.
// - After reset or general-call reset a conversion starts at once.
// - Power-down bit set: finish current conversion, then shut down.
// - Power-down bit clear: continuous conversion at selected rate.
// - Rising edge of internal shutdown clears alert and fault counter.
// - Rewriting power-down while shut down clears nothing.
// - In shutdown, writing single-shot bit 1 starts one conversion.
// - Single-shot completion updates result and returns to shutdown.
// - Single-shot bit always reads back 0.
// - A write of only the high byte updates only that byte.
// - Result is 12 bits in the top of the 16-bit register.
// - Thermostat bit: 0 comparator alert, 1 interrupt alert.
module tcmc_top #(
   parameter int CONV_CYC = tcmc_pkg::CONV_CYCLES,
   parameter int DELAY18_CYC = tcmc_pkg::DELAY_18_CYCLES,
   parameter int DELAY9_CYC = tcmc_pkg::DELAY_9_CYCLES,
   parameter int DELAY4_CYC = tcmc_pkg::DELAY_4_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_gencall_reset,
   input wire logic [2:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [1:0] i_byte_en,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic [11:0] i_adc_sample,
   output logic o_adc_power,
   output logic o_shutdown,
   output logic o_alert_clear,
   output logic o_thermostat_mode,
   output logic [1:0] o_fault_queue,
   output logic o_alert_pol,
   output logic [15:0] o_tlow,
   output logic [15:0] o_thigh,
   output logic o_result_valid,
   output logic o_irq
);
   localparam int CW = 34;

   tcmc_pkg::tcmc_req_t req;
   tcmc_pkg::tcmc_state_t state_r;
   logic [15:0] conf_r;
   logic [15:0] tlow_r;
   logic [15:0] thigh_r;
   logic [15:0] temp_r;
   logic [CW-1:0] cnt_r;
   // Wide enough for the longest idle delay at the rated clock
   logic [CW-1:0] delay_cyc;

   logic single_pend_r;
   logic single_run_r;
   logic shut_r;
   logic shut_d_r;

   logic [tcmc_pkg::IRQ_W-1:0] irq_stat_r;
   logic [tcmc_pkg::IRQ_W-1:0] irq_mask_r;
   logic [tcmc_pkg::IRQ_W-1:0] irq_set;
   logic irq_pend;
   logic stat_rd;
   logic mask_wr;

   logic soft_rst;
   logic conv_done;
   logic delay_done;
   logic conf_wr;
   logic single_req;
   logic pd_bit;
   logic [1:0] rate;
   logic shut_rise;

   logic [15:0] rd_mux;

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd, byte_en: i_byte_en};
   assign soft_rst = !i_reset_n || i_gencall_reset;
   assign pd_bit = conf_r[tcmc_pkg::CONF_POWER_DOWN_POS];
   assign rate = {conf_r[tcmc_pkg::CONF_RATE_HI_POS], conf_r[tcmc_pkg::CONF_RATE_LO_POS]};
   assign conf_wr = req.wr && req.addr == {1'b0, tcmc_pkg::ADDR_CONF};
   // A write that also clears power-down leaves shutdown, so it starts no single shot
   assign single_req = conf_wr && req.byte_en[1]
      && req.wdata[tcmc_pkg::CONF_SINGLE_SHOT_POS]
      && req.wdata[tcmc_pkg::CONF_POWER_DOWN_POS];
   assign conv_done = state_r == tcmc_pkg::TCMC_CONVERT
      && cnt_r == CW'(CONV_CYC - 1);
   // A rate of 00 written in mid-delay ends the delay at once instead of hanging
   assign delay_done = state_r == tcmc_pkg::TCMC_DELAY
      && (delay_cyc == '0
      || cnt_r >= delay_cyc - CW'(1));
   assign shut_rise = shut_r && !shut_d_r;
   assign stat_rd = req.rd && req.addr == tcmc_pkg::ADDR_IRQ_STAT;
   assign mask_wr = req.wr && req.addr == tcmc_pkg::ADDR_IRQ_MASK;

   // Delay after a conversion, chosen by the rate field
   always_comb begin
      case (rate)
         2'b01: begin
            delay_cyc = CW'(DELAY18_CYC);
         end
         2'b10: begin
            delay_cyc = CW'(DELAY9_CYC);
         end
         2'b11: begin
            delay_cyc = CW'(DELAY4_CYC);
         end
         default: begin
            delay_cyc = '0;
         end
      endcase
   end

   // Configuration and limit registers, byte-wise writable
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         conf_r <= tcmc_pkg::CONF_RESET;
         tlow_r <= tcmc_pkg::TLOW_RESET;
         thigh_r <= tcmc_pkg::THIGH_RESET;
      end else if (req.wr && !req.addr[2]) begin
         // Reserved low byte of the configuration is not stored; it reads as all ones
         case (req.addr[1:0])
            tcmc_pkg::ADDR_CONF: begin
               if (req.byte_en[1]) begin
                  conf_r[15:8] <= {1'b0, req.wdata[14:8]};
               end
            end

            tcmc_pkg::ADDR_TLOW: begin
               if (req.byte_en[1]) begin
                  tlow_r[15:8] <= req.wdata[15:8];
               end
               if (req.byte_en[0]) begin
                  tlow_r[7:4] <= req.wdata[7:4];
               end
            end

            tcmc_pkg::ADDR_THIGH: begin
               if (req.byte_en[1]) begin
                  thigh_r[15:8] <= req.wdata[15:8];
               end
               if (req.byte_en[0]) begin
                  thigh_r[7:4] <= req.wdata[7:4];
               end
            end

            default: begin
            end
         endcase
      end
   end

   // Single-shot request taken only in shutdown, held until the sequencer leaves it
   // A request outside shutdown is dropped; the running mode has no use for it
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         single_pend_r <= 1'b0;
      end else if (single_req && state_r == tcmc_pkg::TCMC_SHUTDOWN) begin
         single_pend_r <= 1'b1;
      end else if (state_r != tcmc_pkg::TCMC_SHUTDOWN) begin
         single_pend_r <= 1'b0;
      end
   end

   // Conversion sequencer
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         state_r <= tcmc_pkg::TCMC_CONVERT;
         cnt_r <= '0;
         single_run_r <= 1'b0;
      end else begin
         case (state_r)
            tcmc_pkg::TCMC_CONVERT: begin
               if (conv_done) begin
                  cnt_r <= '0;
                  if (pd_bit || single_run_r) begin
                     state_r <= tcmc_pkg::TCMC_SHUTDOWN;
                  end else if (rate == 2'b00) begin
                     state_r <= tcmc_pkg::TCMC_CONVERT;
                  end else begin
                     state_r <= tcmc_pkg::TCMC_DELAY;
                  end
                  single_run_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + CW'(1);
               end
            end

            tcmc_pkg::TCMC_DELAY: begin
               if (pd_bit) begin
                  state_r <= tcmc_pkg::TCMC_SHUTDOWN;
                  cnt_r <= '0;
               end else if (delay_done) begin
                  state_r <= tcmc_pkg::TCMC_CONVERT;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + CW'(1);
               end
            end

            tcmc_pkg::TCMC_SHUTDOWN: begin
               // Register side stays up; only the converter is idle here
               cnt_r <= '0;
               if (single_pend_r) begin
                  state_r <= tcmc_pkg::TCMC_CONVERT;
                  single_run_r <= 1'b1;
               end else if (!pd_bit) begin
                  state_r <= tcmc_pkg::TCMC_CONVERT;
               end
            end

            default: begin
               state_r <= tcmc_pkg::TCMC_CONVERT;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // Result register: whole word written in one edge, so reads never mix conversions
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         temp_r <= tcmc_pkg::TEMP_RESET;
         o_result_valid <= 1'b0;
      end else if (conv_done) begin
         temp_r <= {i_adc_sample, 4'h0};
         o_result_valid <= 1'b1;
      end
   end

   // Internal shutdown signal and its rising edge
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         shut_r <= 1'b0;
         shut_d_r <= 1'b0;
      end else begin
         shut_r <= state_r == tcmc_pkg::TCMC_SHUTDOWN && !single_run_r;
         shut_d_r <= shut_r;
      end
   end

   // Edge only, so a repeated power-down write while shut down clears nothing
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         o_alert_clear <= 1'b0;
      end else begin
         o_alert_clear <= shut_rise;
      end
   end

   // Interrupt status: set wins over read-clear
   assign irq_set[tcmc_pkg::IRQ_DONE_POS] = conv_done;
   assign irq_set[tcmc_pkg::IRQ_SHUTDOWN_POS] = shut_rise;
   assign irq_set[tcmc_pkg::IRQ_SINGLE_POS] = conv_done && single_run_r;
   // Counting the event in its own cycle raises the line one clock sooner
   assign irq_pend = |((irq_stat_r | irq_set) & irq_mask_r);

   // One sticky bit per event
   for (genvar gi = 0; gi < tcmc_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge i_clk) begin
         if (soft_rst) begin
            irq_stat_r[gi] <= 1'b0;
         end else if (irq_set[gi]) begin
            irq_stat_r[gi] <= 1'b1;
         end else if (stat_rd) begin
            irq_stat_r[gi] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         irq_mask_r <= '0;
      end else if (mask_wr) begin
         irq_mask_r <= req.wdata[tcmc_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_pend;
      end
   end

   // Read multiplexer; unmapped reads give zero
   always_comb begin
      case (req.addr)
         {1'b0, tcmc_pkg::ADDR_TEMP}: begin
            rd_mux = temp_r;
         end
         {1'b0, tcmc_pkg::ADDR_CONF}: begin
            rd_mux = {1'b0, conf_r[14:8], tcmc_pkg::CONF_RESERVED};
         end
         {1'b0, tcmc_pkg::ADDR_TLOW}: begin
            rd_mux = {tlow_r[15:4], 4'h0};
         end
         {1'b0, tcmc_pkg::ADDR_THIGH}: begin
            rd_mux = {thigh_r[15:4], 4'h0};
         end
         tcmc_pkg::ADDR_IRQ_STAT: begin
            rd_mux = {13'h0000, irq_stat_r};
         end
         tcmc_pkg::ADDR_IRQ_MASK: begin
            rd_mux = {13'h0000, irq_mask_r};
         end
         tcmc_pkg::ADDR_SAMPLE: begin
            rd_mux = {4'h0, i_adc_sample};
         end
         tcmc_pkg::ADDR_STATE: begin
            rd_mux = {13'h0000, single_run_r, state_r};
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // Read data stand in the cycle after the strobe only
   always_ff @(posedge i_clk) begin
      if (soft_rst) begin
         o_rdata <= '0;
      end else if (req.rd) begin
         o_rdata <= rd_mux;
      end else begin
         o_rdata <= '0;
      end
   end

   assign o_adc_power = state_r == tcmc_pkg::TCMC_CONVERT;
   assign o_shutdown = shut_r;
   assign o_thermostat_mode = conf_r[tcmc_pkg::CONF_THERMOSTAT_POS];
   assign o_fault_queue = conf_r[12:11];
   assign o_alert_pol = conf_r[10];
   assign o_tlow = tlow_r;
   assign o_thigh = thigh_r;
endmodule // tcmc_top

//--- bench/tcmc_checker_asserts.sv
`timescale 1ns/1ns
module tcmc_checker #(
   parameter int CONV_CYC = 20
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_gencall_reset,
   input wire logic [2:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [1:0] i_byte_en,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic o_adc_power,
   input wire logic o_shutdown,
   input wire logic o_alert_clear,
   input wire logic o_thermostat_mode,
   input wire logic o_result_valid
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   int cnt_r;
   logic seen_r;
   // A general-call reset aborts a conversion, so the run count starts over
   always_ff @(posedge i_clk) begin
      if (!i_reset_n || i_gencall_reset) begin
         cnt_r <= 0;
         seen_r <= 1'b0;
      end else begin
         cnt_r <= o_adc_power ? cnt_r + 1 : 0;
         seen_r <= seen_r | $rose(o_adc_power);
      end
   end
   a_ss_reads_zero: assert property ($past(i_rd) && $past(i_addr) == 3'h1 |-> !o_rdata[15])
      else $error("single-shot bit read back as one");
   a_temp_nibble: assert property ($past(i_rd) && $past(i_addr) == 3'h0 |-> o_rdata[3:0] == 4'h0)
      else $error("result low nibble not zero");
   a_shut_clears: assert property ($rose(o_shutdown) |-> ##[0:1] o_alert_clear)
      else $error("no alert clear on shutdown entry");
   a_no_reclear: assert property (o_shutdown && $past(o_shutdown) && $past(o_shutdown, 2)
      |-> !o_alert_clear)
      else $error("alert clear while already shut down");
   a_shut_quiet: assert property (o_shutdown |-> !$past(o_adc_power))
      else $error("converter powered in shutdown");
   a_conv_len: assert property ($fell(o_adc_power) && seen_r |-> cnt_r % CONV_CYC == 0)
      else $error("conversion run length wrong");
   a_first_result: assert property ($rose(o_result_valid) |-> $past(o_adc_power))
      else $error("result valid without conversion");
   a_tm_write: assert property ($past(i_wr) && $past(i_addr) == 3'h1 && ($past(i_byte_en) & 2'b10) != 0
      |-> o_thermostat_mode == $past(i_wdata[9]))
      else $error("thermostat mode not taken");
   c_shut: cover property ($rose(o_shutdown));
   c_clear: cover property (o_alert_clear);
   c_valid: cover property ($rose(o_result_valid));
endmodule // tcmc_checker

bind tcmc_top tcmc_checker #(.CONV_CYC(CONV_CYC)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_gencall_reset(i_gencall_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_byte_en(i_byte_en),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_adc_power(o_adc_power),
   .o_shutdown(o_shutdown), .o_alert_clear(o_alert_clear),
   .o_thermostat_mode(o_thermostat_mode), .o_result_valid(o_result_valid));

//--- bench/tcmc_master.sv
`timescale 1ns/1ns
module tcmc_master (
   input wire logic i_clk,
   output logic [2:0] o_addr,
   output logic [15:0] o_wdata,
   output logic [1:0] o_byte_en,
   output logic o_wr,
   output logic o_rd
);
   initial begin
      o_addr = 3'h0;
      o_wdata = 16'h0000;
      o_byte_en = 2'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Released lines show the inverse, so a stale value cannot pass
   task automatic put(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
      o_addr <= a;
      o_wdata <= d;
      o_byte_en <= be;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
      @(posedge i_clk);
   endtask
   // One unit per read, then the request is dropped
   task automatic get(input logic [2:0] a);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_clk);
   endtask
endmodule // tcmc_master

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int CONV = 20;
   localparam int DLY [4] = '{0, 10, 20, 40};
   localparam logic [2:0] AT = {1'b0, tcmc_pkg::ADDR_TEMP};
   localparam logic [2:0] AC = {1'b0, tcmc_pkg::ADDR_CONF};
   localparam logic [2:0] AL = {1'b0, tcmc_pkg::ADDR_TLOW};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic gc = 1'b0;
   logic [11:0] smp = 12'h000;
   logic [11:0] s;
   logic [7:0] b;
   logic [2:0] addr;
   logic [15:0] wd, rdata, ex;
   logic [1:0] be;
   logic wr, rd, pwr, sd, clr, tm, irq;
   logic [15:0] tlo, thi;
   logic [1:0] fq;
   logic pol, vld;
   logic rd_d = 1'b0;
   logic [15:0] q [$];
   int n_errors = 0, total_checks = 0, n_clr = 0, cyc = 0, n, c0;
   always #2 clk = ~clk;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
   tcmc_master m (.i_clk(clk), .o_addr(addr), .o_wdata(wd), .o_byte_en(be), .o_wr(wr), .o_rd(rd));
   tcmc_top #(.CONV_CYC(CONV), .DELAY18_CYC(10), .DELAY9_CYC(20), .DELAY4_CYC(40)) uut (
      .i_clk(clk), .i_reset_n(rst_n), .i_gencall_reset(gc), .i_addr(addr), .i_wdata(wd),
      .i_byte_en(be), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_adc_sample(smp),
      .o_adc_power(pwr), .o_shutdown(sd), .o_alert_clear(clr), .o_thermostat_mode(tm),
      .o_fault_queue(fq), .o_alert_pol(pol), .o_tlow(tlo), .o_thigh(thi), .o_result_valid(vld),
      .o_irq(irq));
   task automatic finish_test();
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Read data stand one cycle only, so they are taken at the next edge
   always @(posedge clk) begin
      cyc++;
      if (clr) n_clr++;
      if (rd_d) begin
         ex = q.pop_front();
         `CHK(rdata, ex)
      end
      rd_d <= rd;
      if (cyc > 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic rchk(input logic [2:0] a, input logic [15:0] e);
      q.push_back(e);
      m.get(a);
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic gap(output int k);
      @(negedge pwr);
      k = 0;
      do begin
         @(posedge clk);
         k += int'(!pwr);
      end while (!pwr);
   endtask
   initial begin
      void'($urandom(90));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      `CHK(tm, 1'b0)
      `CHK(vld, 1'b0)
      rchk(AC, tcmc_pkg::CONF_RESET);
      rchk(AT, tcmc_pkg::TEMP_RESET);
      repeat (2) begin
         s = 12'($urandom);
         smp <= s;
         idle(2 * CONV);
         rchk(AT, {s, 4'h0});
      end
      `CHK(vld, 1'b1)
      n = 0;
      repeat (3 * CONV) begin
         @(posedge clk);
         n += int'(!pwr);
      end
      `CHK(n, 0)
      for (int r = 1; r < 4; r++) begin
         m.put(AC, {1'b0, 2'(r), 13'h0}, 2'b10);
         gap(n);
         gap(n);
         `CHK(n, DLY[r])
      end
      m.put(AC, 16'h1e00, 2'b10);
      `CHK(tm, 1'b1)
      `CHK(fq, 2'b11)
      `CHK(pol, 1'b1)
      c0 = n_clr;
      m.put(AC, 16'h0100, 2'b10);
      wait (sd === 1'b1);
      idle(3);
      `CHK(n_clr, c0 + 1)
      `CHK(pwr, 1'b0)
      m.put(AC, 16'h0100, 2'b10);
      idle(3);
      `CHK(n_clr, c0 + 1)
      m.put(tcmc_pkg::ADDR_IRQ_MASK, 16'h0007, 2'b11);
      rchk(tcmc_pkg::ADDR_IRQ_STAT, 16'h0003);
      idle(2);
      `CHK(irq, 1'b0)
      m.put(tcmc_pkg::ADDR_IRQ_MASK, 16'h0004, 2'b11);
      s = 12'($urandom);
      smp <= s;
      m.put(AC, 16'h8100, 2'b10);
      wait (pwr === 1'b1);
      wait (pwr === 1'b0);
      idle(2 * CONV);
      `CHK(pwr, 1'b0)
      `CHK(irq, 1'b1)
      rchk(AT, {s, 4'h0});
      rchk(AC, 16'h01ff);
      rchk(tcmc_pkg::ADDR_IRQ_STAT, 16'h0007);
      rchk(tcmc_pkg::ADDR_STATE, 16'h0003);
      rchk(tcmc_pkg::ADDR_SAMPLE, {4'h0, s});
      idle(2);
      `CHK(irq, 1'b0)
      b = 8'($urandom);
      m.put(AL, {b, 8'h5a}, 2'b10);
      rchk(AL, {b, 8'h00});
      m.put(AL, 16'hffff, 2'b01);
      rchk(AL, {b, 8'hf0});
      `CHK(tlo, {b, 8'hf0})
      m.put(3'h3, 16'h5a5a, 2'b10);
      `CHK(thi, 16'h5a00)
      m.put(AT, 16'hffff, 2'b11);
      rchk(AT, {s, 4'h0});
      m.put(AC, 16'h0000, 2'b10);
      wait (pwr === 1'b1);
      idle(3);
      `CHK(sd, 1'b0)
      gc <= 1'b1;
      idle(1);
      gc <= 1'b0;
      rchk(AC, tcmc_pkg::CONF_RESET);
      `CHK(pwr, 1'b1)
      idle(CONV + 4);
      rchk(AT, {s, 4'h0});
      idle(2);
      finish_test();
   end
endmodule // testbench
